// ===== verilog/dual_i2c_register_port.sv
// main and power two-wire target engines over the shared register array
`timescale 1ns/1ps
module dual_i2c_register_port
   import i2c_port_pkg::*;
#(
   parameter logic [255:0] READ_MASK = DEF_READ_MASK,
   parameter logic [255:0] WRITE_MASK = DEF_WRITE_MASK,
   parameter logic [7:0] TOP_ADDR = DEF_TOP_ADDR
)
(
   // clock and sequencer reset
   input wire logic ref_clk,
   input wire logic rst,
   // main bus pins
   input wire logic mainSclIn,
   input wire logic mainSdaIn,
   output logic mainSdaOut,
   output logic mainSdaOe,
   // power bus pins
   input wire logic powerSclIn,
   input wire logic powerSdaIn,
   output logic powerSdaOut,
   output logic powerSdaOe,
   // device-side register view
   input wire logic [7:0] devRdAddr,
   output logic [7:0] devRdData,
   output reg_write_type regWrite
);
   // a writable location must also be an allowed pointer target
   if ((WRITE_MASK & ~READ_MASK) != NO_LOCATIONS)
   begin : g_bad_masks
      $error("write mask names locations the read mask forbids");
   end

   logic [7:0] regFile [0:REG_COUNT-1];
   bus_event_type mainEvt;
   bus_event_type powerEvt;
   reg_write_type powerWr;
   reg_write_type mainWr_r;
   logic powerOe;

   main_state_type state_r, state_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic [7:0] txShift_r, txShift_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic gotByte_r, gotByte_nxt;
   logic readMode_r, readMode_nxt;
   logic hostAck_r, hostAck_nxt;
   logic wrapped_r, wrapped_nxt;
   logic oe_nxt;
   logic commit;

   i2c_line_front u_main_front (
      .ref_clk(ref_clk),
      .rst(rst),
      .sclPin(mainSclIn),
      .sdaPin(mainSdaIn),
      .evt(mainEvt)
   );

   i2c_line_front u_power_front (
      .ref_clk(ref_clk),
      .rst(rst),
      .sclPin(powerSclIn),
      .sdaPin(powerSdaIn),
      .evt(powerEvt)
   );

   // the power engine keeps its own pointer
   i2c_power_engine #(
      .READ_MASK(READ_MASK),
      .WRITE_MASK(WRITE_MASK)
   ) u_power (
      .ref_clk(ref_clk),
      .rst(rst),
      .evt(powerEvt),
      .sdaOe(powerOe),
      .wr(powerWr)
   );

   // byte decode for the receiving states
   wire [7:0] ramRd = regFile[ptr_r];
   wire isWriteAddr = (shift_r == WRITE_ADDR_BYTE);
   wire isReadAddr = (shift_r == READ_ADDR_BYTE);
   wire ptrOk = maskHit(READ_MASK, shift_r);
   wire byteAck = (state_r == M_ADDR) ? (isWriteAddr || isReadAddr) :
                  (state_r == M_PTR) ? ptrOk : 1'b1;
   wire rxState = (state_r == M_ADDR) || (state_r == M_PTR) || (state_r == M_DATA);
   wire lastPtr = (ptr_r == TOP_ADDR);
   wire [7:0] ptrInc = lastPtr ? PTR_WRAP_VALUE : ptr_r + PTR_STEP;
   main_state_type byteDest;
   assign byteDest = !byteAck ? M_IGNORE :
                     (state_r == M_ADDR) ? M_ADDR_ACK :
                     (state_r == M_PTR) ? M_PTR_ACK : M_DATA_ACK;

   // main engine sequencing; stop and start win over any transfer
   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      ptr_nxt = ptr_r;
      txShift_nxt = txShift_r;
      bitCnt_nxt = bitCnt_r;
      gotByte_nxt = gotByte_r;
      readMode_nxt = readMode_r;
      hostAck_nxt = hostAck_r;
      wrapped_nxt = wrapped_r;
      oe_nxt = mainSdaOe;
      commit = 1'b0;
      if (mainEvt.stopSeen)
      begin
         state_nxt = M_IDLE;
         oe_nxt = 1'b0;
      end
      else if (mainEvt.startSeen)
      begin
         state_nxt = M_ADDR;
         bitCnt_nxt = FIRST_BIT;
         gotByte_nxt = 1'b0;
         wrapped_nxt = 1'b0;
         oe_nxt = 1'b0;
      end
      else
      begin
         unique case (state_r)
            M_IDLE, M_IGNORE:
            begin
               oe_nxt = 1'b0;
            end
            M_ADDR, M_PTR, M_DATA:
            begin
               if (mainEvt.sclRise)
               begin
                  shift_nxt = {shift_r[6:0], mainEvt.sdaLevel};
                  bitCnt_nxt = bitCnt_r + BIT_STEP;
                  gotByte_nxt = (bitCnt_r == LAST_BIT);
               end
               else if (mainEvt.sclFall && gotByte_r)
               begin
                  gotByte_nxt = 1'b0;
                  bitCnt_nxt = FIRST_BIT;
                  state_nxt = byteDest;
                  oe_nxt = byteAck;
                  if (state_r == M_PTR && ptrOk)
                     ptr_nxt = shift_r;
                  if (state_r == M_ADDR)
                     readMode_nxt = isReadAddr;
               end
            end
            M_ADDR_ACK:
            begin
               if (mainEvt.sclFall && readMode_r)
               begin
                  state_nxt = M_TX;
                  txShift_nxt = ramRd;
                  oe_nxt = ~ramRd[7];
                  bitCnt_nxt = FIRST_BIT;
               end
               else if (mainEvt.sclFall)
               begin
                  state_nxt = M_PTR;
                  oe_nxt = 1'b0;
               end
            end
            M_PTR_ACK:
            begin
               if (mainEvt.sclFall)
               begin
                  state_nxt = M_DATA;
                  oe_nxt = 1'b0;
               end
            end
            M_DATA_ACK:
            begin
               // one byte per write; further bytes are refused
               if (mainEvt.sclFall)
               begin
                  state_nxt = M_IGNORE;
                  oe_nxt = 1'b0;
                  commit = maskHit(WRITE_MASK, ptr_r);
               end
            end
            M_TX:
            begin
               if (mainEvt.sclFall && bitCnt_r == LAST_BIT)
               begin
                  state_nxt = M_HOST_ACK;
                  oe_nxt = 1'b0;
                  ptr_nxt = ptrInc;
                  wrapped_nxt = lastPtr;
               end
               else if (mainEvt.sclFall)
               begin
                  bitCnt_nxt = bitCnt_r + BIT_STEP;
                  txShift_nxt = {txShift_r[6:0], 1'b0};
                  oe_nxt = ~txShift_r[6];
               end
            end
            M_HOST_ACK:
            begin
               if (mainEvt.sclRise)
                  hostAck_nxt = ~mainEvt.sdaLevel;
               else if (mainEvt.sclFall && hostAck_r && !wrapped_r)
               begin
                  state_nxt = M_TX;
                  txShift_nxt = ramRd;
                  oe_nxt = ~ramRd[7];
                  bitCnt_nxt = FIRST_BIT;
               end
               else if (mainEvt.sclFall)
                  state_nxt = M_IGNORE;
            end
         endcase
      end
   end

   // engine state
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= M_IDLE;
         shift_r <= REG_RESET_VALUE;
         ptr_r <= PTR_RESET_VALUE;
         txShift_r <= REG_RESET_VALUE;
         bitCnt_r <= FIRST_BIT;
         gotByte_r <= 1'b0;
         readMode_r <= 1'b0;
         hostAck_r <= 1'b0;
         wrapped_r <= 1'b0;
         mainSdaOe <= 1'b0;
         mainWr_r <= '{valid: 1'b0, addr: PTR_RESET_VALUE, data: REG_RESET_VALUE};
      end
      else
      begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         ptr_r <= ptr_nxt;
         txShift_r <= txShift_nxt;
         bitCnt_r <= bitCnt_nxt;
         gotByte_r <= gotByte_nxt;
         readMode_r <= readMode_nxt;
         hostAck_r <= hostAck_nxt;
         wrapped_r <= wrapped_nxt;
         mainSdaOe <= oe_nxt;
         mainWr_r <= '{valid: commit, addr: ptr_r, data: shift_r};
      end
   end

   // register array; a same-cycle clash on one location goes to the power engine
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regFile[i] <= REG_RESET_VALUE;
      end
      else
      begin
         if (mainWr_r.valid)
            regFile[mainWr_r.addr] <= mainWr_r.data;
         if (powerWr.valid)
            regFile[powerWr.addr] <= powerWr.data;
      end
   end

   // pin and device-side outputs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mainSdaOut <= 1'b0;
         powerSdaOut <= 1'b0;
         powerSdaOe <= 1'b0;
         devRdData <= REG_RESET_VALUE;
         regWrite <= '{valid: 1'b0, addr: PTR_RESET_VALUE, data: REG_RESET_VALUE};
      end
      else
      begin
         mainSdaOut <= 1'b0;
         powerSdaOut <= 1'b0;
         powerSdaOe <= powerOe;
         devRdData <= regFile[devRdAddr];
         regWrite <= powerWr.valid ? powerWr : mainWr_r;
      end
   end

   chk_own_addr_ack: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_ADDR && mainEvt.sclFall && gotByte_r && (isWriteAddr || isReadAddr))
      |=> (state_r == M_ADDR_ACK && mainSdaOe))
      else $error("own address not acknowledged");
   chk_foreign_nack: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_ADDR && mainEvt.sclFall && gotByte_r && !isWriteAddr && !isReadAddr)
      |=> (state_r == M_IGNORE && !mainSdaOe))
      else $error("foreign address was acknowledged");
   chk_ptr_load: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_PTR && mainEvt.sclFall && gotByte_r && ptrOk)
      |=> (ptr_r == $past(shift_r) && mainSdaOe))
      else $error("allowed pointer not loaded and acknowledged");
   chk_ptr_refuse: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_PTR && mainEvt.sclFall && gotByte_r && !ptrOk)
      |=> (ptr_r == $past(ptr_r) && !mainSdaOe && state_r == M_IGNORE))
      else $error("reserved pointer loaded or acknowledged");
   chk_commit_gate: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_DATA_ACK && mainEvt.sclFall)
      |=> (mainWr_r.valid == maskHit(WRITE_MASK, ptr_r) && mainWr_r.addr == ptr_r) ##1
      (!mainWr_r.valid))
      else $error("data commit wrong at end of acknowledge");
   chk_write_cancel: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r inside {M_DATA, M_DATA_ACK} && (mainEvt.startSeen || mainEvt.stopSeen))
      |=> (!mainWr_r.valid)[*3])
      else $error("cancelled write still committed");
   chk_stop_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (mainEvt.stopSeen |=> (state_r == M_IDLE && !mainSdaOe)) and
      ((mainEvt.startSeen && !mainEvt.stopSeen) |=> (state_r == M_ADDR && bitCnt_r == FIRST_BIT)))
      else $error("stop or start not honoured");
   chk_read_source: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_ADDR_ACK && readMode_r && mainEvt.sclFall && !mainEvt.stopSeen)
      |=> (state_r == M_TX && txShift_r == $past(ramRd) && mainSdaOe == ~txShift_r[7]))
      else $error("read did not start at the pointer");
   chk_read_step: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_TX && mainEvt.sclFall && bitCnt_r == LAST_BIT)
      |=> (ptr_r == (($past(ptr_r) == TOP_ADDR) ? PTR_WRAP_VALUE : $past(ptr_r) + PTR_STEP)))
      else $error("pointer did not step after a returned byte");
   chk_wrap_end: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == M_HOST_ACK && wrapped_r && mainEvt.sclFall)
      |=> (state_r == M_IGNORE) ##1 (!mainSdaOe))
      else $error("read continued past the wrap");
endmodule

// ===== verilog/i2c_port_pkg.sv
// shared constants, types and decode helpers for the dual register port
package i2c_port_pkg;
   // bus address bytes: write and read forms of the fixed target address
   localparam logic [7:0] WRITE_ADDR_BYTE = 8'h68;
   localparam logic [7:0] READ_ADDR_BYTE = 8'h69;
   // pointer behaviour
   localparam logic [7:0] PTR_WRAP_VALUE = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] PTR_RESET_VALUE = 8'h00;
   localparam logic [7:0] DEF_TOP_ADDR = 8'hff;
   localparam int REG_COUNT = 256;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // default decode table: every location readable and writable
   localparam logic [255:0] DEF_READ_MASK = {64{4'hf}};
   localparam logic [255:0] DEF_WRITE_MASK = {64{4'hf}};
   localparam logic [255:0] NO_LOCATIONS = {64{4'h0}};
   // bit counting within a byte
   localparam logic [2:0] FIRST_BIT = 3'h0;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] BIT_STEP = 3'h1;
   // synchroniser reset image, lines idle high
   localparam logic [2:0] SYNC_IDLE = 3'h7;

   // bus conditions seen on one filtered clock/data pair
   typedef struct packed {
      logic sclRise;
      logic sclFall;
      logic startSeen;
      logic stopSeen;
      logic sdaLevel;
   } bus_event_type;

   // one committed register write
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_type;

   typedef enum logic [3:0] {
      M_IDLE, M_ADDR, M_ADDR_ACK, M_PTR, M_PTR_ACK, M_DATA, M_DATA_ACK, M_TX, M_HOST_ACK, M_IGNORE
   } main_state_type;

   typedef enum logic [2:0] {
      P_IDLE, P_ADDR, P_ADDR_ACK, P_PTR, P_PTR_ACK, P_DATA, P_DATA_ACK, P_IGNORE
   } power_state_type;

   // decode table lookup
   function automatic logic maskHit(input logic [255:0] mask, input logic [7:0] idx);
      return mask[idx];
   endfunction
endpackage

// ===== verilog/i2c_line_front.sv
// pin synchroniser and start/stop/edge detector for one two-wire bus
`timescale 1ns/1ps
module i2c_line_front
   import i2c_port_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // bus pins as seen on the wire
   input wire logic sclPin,
   input wire logic sdaPin,
   // decoded conditions, valid in the cycle the filtered level changes
   output bus_event_type evt
);
   logic [2:0] sclSync_r;
   logic [2:0] sdaSync_r;
   logic sclLvl_r;
   logic sdaLvl_r;
   wire sclAgree = (sclSync_r[1] == sclSync_r[2]);
   wire sdaAgree = (sdaSync_r[1] == sdaSync_r[2]);
   wire sclNew = sclAgree ? sclSync_r[2] : sclLvl_r;
   wire sdaNew = sdaAgree ? sdaSync_r[2] : sdaLvl_r;

   // three stages; a level counts once the last two agree
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclSync_r <= SYNC_IDLE;
         sdaSync_r <= SYNC_IDLE;
         sclLvl_r <= 1'b1;
         sdaLvl_r <= 1'b1;
      end
      else
      begin
         sclSync_r <= {sclSync_r[1:0], sclPin};
         sdaSync_r <= {sdaSync_r[1:0], sdaPin};
         sclLvl_r <= sclNew;
         sdaLvl_r <= sdaNew;
      end
   end

   // events left combinational: a registered copy would eat the short low phase
   assign evt.sclRise = sclNew & ~sclLvl_r;
   assign evt.sclFall = ~sclNew & sclLvl_r;
   assign evt.startSeen = sclLvl_r & sclNew & sdaLvl_r & ~sdaNew;
   assign evt.stopSeen = sclLvl_r & sclNew & ~sdaLvl_r & sdaNew;
   assign evt.sdaLevel = sdaNew;
endmodule

// ===== verilog/i2c_power_engine.sv
// write-only engine: register pointer and data pairs until stop
`timescale 1ns/1ps
module i2c_power_engine
   import i2c_port_pkg::*;
#(
   parameter logic [255:0] READ_MASK = DEF_READ_MASK,
   parameter logic [255:0] WRITE_MASK = DEF_WRITE_MASK
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // filtered bus conditions
   input bus_event_type evt,
   // data line pull-down and committed writes
   output logic sdaOe,
   output reg_write_type wr
);
   power_state_type state_r, state_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic gotByte_r, gotByte_nxt;
   logic oe_nxt;
   logic commit;

   // only the write form of the address is ever acknowledged here
   wire byteAck = (state_r == P_ADDR) ? (shift_r == WRITE_ADDR_BYTE) :
                  (state_r == P_PTR) ? maskHit(READ_MASK, shift_r) : 1'b1;
   wire rxState = (state_r == P_ADDR) || (state_r == P_PTR) || (state_r == P_DATA);
   wire ackState = (state_r == P_ADDR_ACK) || (state_r == P_PTR_ACK) || (state_r == P_DATA_ACK);

   // protocol sequencing; stop and start override everything
   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      ptr_nxt = ptr_r;
      bitCnt_nxt = bitCnt_r;
      gotByte_nxt = gotByte_r;
      oe_nxt = sdaOe;
      commit = 1'b0;
      if (evt.stopSeen)
      begin
         state_nxt = P_IDLE;
         oe_nxt = 1'b0;
      end
      else if (evt.startSeen)
      begin
         state_nxt = P_ADDR;
         bitCnt_nxt = FIRST_BIT;
         gotByte_nxt = 1'b0;
         oe_nxt = 1'b0;
      end
      else if (rxState && evt.sclRise)
      begin
         shift_nxt = {shift_r[6:0], evt.sdaLevel};
         bitCnt_nxt = bitCnt_r + BIT_STEP;
         gotByte_nxt = (bitCnt_r == LAST_BIT);
      end
      else if (rxState && evt.sclFall && gotByte_r)
      begin
         gotByte_nxt = 1'b0;
         bitCnt_nxt = FIRST_BIT;
         oe_nxt = byteAck;
         if (!byteAck)
            state_nxt = P_IGNORE;
         else if (state_r == P_ADDR)
            state_nxt = P_ADDR_ACK;
         else if (state_r == P_PTR)
         begin
            state_nxt = P_PTR_ACK;
            ptr_nxt = shift_r;
         end
         else
            state_nxt = P_DATA_ACK;
      end
      else if (ackState && evt.sclFall)
      begin
         oe_nxt = 1'b0;
         state_nxt = (state_r == P_PTR_ACK) ? P_DATA : P_PTR;
         commit = (state_r == P_DATA_ACK) && maskHit(WRITE_MASK, ptr_r);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= P_IDLE;
         shift_r <= REG_RESET_VALUE;
         ptr_r <= PTR_RESET_VALUE;
         bitCnt_r <= FIRST_BIT;
         gotByte_r <= 1'b0;
         sdaOe <= 1'b0;
         wr <= '{valid: 1'b0, addr: PTR_RESET_VALUE, data: REG_RESET_VALUE};
      end
      else
      begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         ptr_r <= ptr_nxt;
         bitCnt_r <= bitCnt_nxt;
         gotByte_r <= gotByte_nxt;
         sdaOe <= oe_nxt;
         wr <= '{valid: commit, addr: ptr_r, data: shift_r};
      end
   end

   chk_power_ack_only: assert property (@(posedge ref_clk) disable iff (rst)
      sdaOe |-> $past(state_nxt) inside {P_ADDR_ACK, P_PTR_ACK, P_DATA_ACK})
      else $error("power engine drove data line outside an acknowledge");
   chk_power_pair_loop: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == P_DATA_ACK && evt.sclFall) |=> (state_r == P_PTR && !sdaOe) ##0
      (wr.valid == maskHit(WRITE_MASK, wr.addr)))
      else $error("power engine did not return to pointer after a pair");
endmodule

// ===== verif/i2c_host_model.sv
// two-wire bus host that drives one target engine of the port
`timescale 1ns/1ps
module i2c_host_model
(
   // bus lines, data is open drain
   output logic scl,
   output logic sdaLow,
   input wire logic sdaWire
);
   initial
   begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // start, or repeated start when the clock is low; clock left low
   task automatic start();
      if (scl === 1'b0)
      begin
         #100 sdaLow = 1'b0;
         #100 scl = 1'b1;
      end
      #200 sdaLow = 1'b1;
      #200 scl = 1'b0;
   endtask
   // clock idles high after a stop, data released to the pull-up
   task automatic stop();
      #100 sdaLow = 1'b1;
      #100 scl = 1'b1;
      #200 sdaLow = 1'b0;
      #400;
   endtask
   // 400 ns per bit: 200 ns low leaves the target time to drive
   task automatic bitx(input logic b, output logic r);
      #100 sdaLow = ~b;
      #100 scl = 1'b1;
      #100 r = sdaWire;
      #100 scl = 1'b0;
   endtask
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rdByte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(~more, r);
   endtask
endmodule

// ===== verif/dual_i2c_slave_register_port_tb_top.sv
// self-checking bench for the dual register port
`timescale 1ns/1ps
module dual_i2c_slave_register_port_tb_top;
   import i2c_port_pkg::*;
   // 0x80 reserved, 0x40 read-only
   localparam logic [255:0] RMASK = DEF_READ_MASK & ~(256'h1 << 8'h80);
   localparam logic [255:0] WMASK = RMASK & ~(256'h1 << 8'h40);
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic mScl, mLow, pScl, pLow, mOe, pOe, a;
   logic mOut, pOut;
   reg_write_type regWr, lastWr;
   logic [7:0] devRdAddr = 8'h00;
   logic [7:0] devRdData, got, p, d, q;
   logic [7:0] shadow [256];
   logic [31:0] seed = 32'h00006ca7;
   int n_fail = 0;
   int num_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   dual_i2c_register_port #(.READ_MASK(RMASK), .WRITE_MASK(WMASK), .TOP_ADDR(8'hff)) dual_i2c_register_port_i (
      .ref_clk(ref_clk), .rst(rst), .mainSclIn(mScl), .mainSdaIn(~(mLow | mOe)), .mainSdaOut(mOut),
      .mainSdaOe(mOe), .powerSclIn(pScl), .powerSdaIn(~(pLow | pOe)), .powerSdaOut(pOut), .powerSdaOe(pOe),
      .devRdAddr(devRdAddr), .devRdData(devRdData), .regWrite(regWr));
   // keep the last pulse of the device-side write port
   always @(posedge ref_clk)
      if (regWr.valid === 1'b1)
         lastWr <= regWr;
   i2c_host_model i2c_host_model_i (.scl(mScl), .sdaLow(mLow), .sdaWire(~(mLow | mOe)));
   i2c_host_model i2c_host_model_i2 (.scl(pScl), .sdaLow(pLow), .sdaWire(~(pLow | pOe)));
   task automatic chkBit(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // pointer after one returned byte; top location rolls over
   function automatic logic [7:0] nextPtr(input logic [7:0] v);
      return (v == 8'hff) ? 8'h00 : v + 8'h01;
   endfunction
   task automatic mw(input logic [7:0] b, input logic e);
      i2c_host_model_i.wrByte(b, a);
      chkBit("main ack", e, a);
   endtask
   task automatic pw(input logic [7:0] b, input logic e);
      i2c_host_model_i2.wrByte(b, a);
      chkBit("power ack", e, a);
   endtask
   task automatic mr(input logic more, input logic [7:0] e);
      i2c_host_model_i.rdByte(more, got);
      chkByte("main read", e, got);
   endtask
   // commit lands four edges after the clock pin falls, array and view add two more
   task automatic regChk(input logic [7:0] v);
      @(posedge ref_clk);
      #1 devRdAddr = v;
      repeat (6) @(posedge ref_clk);
      #1 chkByte("register", shadow[v], devRdData);
   endtask
   // last write port pulse, and open-drain drive values that must stay low
   task automatic wrChk(input logic [7:0] v);
      chkByte("write port addr", v, lastWr.addr);
      chkByte("write port data", shadow[v], lastWr.data);
      chkBit("pin drive value", 1'b0, mOut | pOut);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #2ms n_fail++;
      end_of_test();
   end
   initial
   begin
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (8) @(posedge ref_clk);
      // host edges then fall 1 ns after a clock edge, never on it
      #1;
      // writes ended alternately by a stop and by the next start
      for (int i = 0; i < 4; i++)
      begin
         p = rnd() & 8'h3f;
         d = rnd();
         i2c_host_model_i.start();
         mw(WRITE_ADDR_BYTE, 1'b1);
         mw(p, 1'b1);
         mw(d, 1'b1);
         shadow[p] = d;
         regChk(p);
         wrChk(p);
         if (i[0])
            i2c_host_model_i.stop();
      end
      // write cut short by a stop inside the data byte
      i2c_host_model_i.start();
      mw(WRITE_ADDR_BYTE, 1'b1);
      mw(p, 1'b1);
      repeat (4) i2c_host_model_i.bitx(1'b0, a);
      i2c_host_model_i.stop();
      regChk(p);
      $display("write test done");
      // foreign address, then everything ignored until stop
      for (int i = 0; i < 3; i++)
      begin
         d = rnd();
         if (d[7:1] == 7'h34)
            d = d ^ 8'h80;
         i2c_host_model_i.start();
         mw(d, 1'b0);
         mw(WRITE_ADDR_BYTE, 1'b0);
         i2c_host_model_i.stop();
      end
      $display("address test done");
      // reserved pointer refused, no stop before the read
      i2c_host_model_i.start();
      mw(WRITE_ADDR_BYTE, 1'b1);
      mw(8'h80, 1'b0);
      i2c_host_model_i.start();
      mw(READ_ADDR_BYTE, 1'b1);
      mr(1'b0, shadow[p]);
      i2c_host_model_i.stop();
      // read-only location, then incremental read ending on it
      i2c_host_model_i.start();
      mw(WRITE_ADDR_BYTE, 1'b1);
      mw(8'h40, 1'b1);
      mw(rnd(), 1'b1);
      i2c_host_model_i.stop();
      regChk(8'h40);
      i2c_host_model_i.start();
      mw(WRITE_ADDR_BYTE, 1'b1);
      mw(8'h3e, 1'b1);
      i2c_host_model_i.start();
      mw(READ_ADDR_BYTE, 1'b1);
      q = 8'h3e;
      for (int i = 0; i < 3; i++)
      begin
         mr(i < 2, shadow[q]);
         q = nextPtr(q);
      end
      i2c_host_model_i.stop();
      $display("read test done");
      // top location: read ends and pointer wraps
      d = rnd();
      i2c_host_model_i.start();
      mw(WRITE_ADDR_BYTE, 1'b1);
      mw(8'hff, 1'b1);
      mw(d, 1'b1);
      i2c_host_model_i.stop();
      shadow[8'hff] = d;
      i2c_host_model_i.start();
      mw(READ_ADDR_BYTE, 1'b1);
      mr(1'b1, d);
      mr(1'b0, 8'hff);
      i2c_host_model_i.stop();
      i2c_host_model_i.start();
      mw(READ_ADDR_BYTE, 1'b1);
      mr(1'b0, shadow[nextPtr(8'hff)]);
      i2c_host_model_i.stop();
      $display("wrap test done");
      // power engine: read refused, then pointer and data pairs
      i2c_host_model_i2.start();
      pw(READ_ADDR_BYTE, 1'b0);
      i2c_host_model_i2.start();
      pw(WRITE_ADDR_BYTE, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         p = rnd() & 8'h3f;
         d = rnd();
         pw(p, 1'b1);
         pw(d, 1'b1);
         shadow[p] = d;
         regChk(p);
         wrChk(p);
      end
      i2c_host_model_i2.stop();
      $display("power test done");
      end_of_test();
   end
endmodule
